// ==== src/cbu_branch_unit.v ====
// Conditional relative branch unit of the 8-bit core
//
// Behaviour
// - Status-bit-clear branch jumps when bit is 0
// - Status-bit-set branch jumps when bit is 1
// - Equal branch jumps when zero flag 1
// - Not-equal branch jumps when zero flag 0
// - Carry-set and lower jump when carry 1
// - Carry-clear and same-or-higher jump on carry 0
// - Minus branch jumps when negative flag 1
// - Plus branch jumps when negative flag 0
// - Signed ge jumps when N xor V 0
// - Signed lt jumps when N xor V 1
// - Half-carry-set jumps when half carry 1
// - Half-carry-clear jumps when half carry 0
// - Transfer-bit-set jumps when transfer bit 1
// - Every branch completes in one or two cycles
// - Branches never alter any status flag
`timescale 1ns/1ps
`include "cbu_defs.vh"

module cbu_branch_unit #(
  parameter PC_W = `CBU_PC_W,
  parameter OFS_W = `CBU_OFS_W
) (
  input wire clk_sys,
  input wire rstn,
  input wire instrValid,
  input wire [`CBU_OP_W-1:0] branchOp,
  input wire [`CBU_SEL_W-1:0] statusBitSel,
  input wire [OFS_W-1:0] branchOffset,
  input wire [PC_W-1:0] pcCurrent,
  input wire [`CBU_CORE_STATUS_REGISTER_W-1:0] coreStatusRegister,
  output reg instrReady_r,
  output reg pcLoad_r,
  output reg [PC_W-1:0] pcTarget_r,
  output reg fetchDiscard_r,
  output reg branchTaken_r,
  output reg branchDone_r,
  output reg [1:0] branchCycles_r
);

  // ***************************************************
  // States
  // ***************************************************
  // Two states: idle, and the discard cycle after a taken jump
  localparam ST_IDLE = 1'b0;
  localparam ST_DISCARD = 1'b1;

  // Cycle figures reported to the core
  localparam [1:0] CYC_SKIP = `CBU_CYC_NOT_TAKEN;
  localparam [1:0] CYC_JUMP = `CBU_CYC_TAKEN;

  // ***************************************************
  // Condition decode
  // ***************************************************
  // Evaluates whether a branch op jumps for a given status byte
  function branchCondition;
    input [`CBU_OP_W-1:0] op;
    input [`CBU_SEL_W-1:0] sel;
    input [`CBU_CORE_STATUS_REGISTER_W-1:0] core_status_register;
    reg flagC;
    reg flagZ;
    reg flagN;
    reg flagV;
    reg flagH;
    reg flagT;
    reg nv;
    begin
      // Name the tested flags once so each arm reads plainly
      flagC = core_status_register[`CBU_BIT_C];
      flagZ = core_status_register[`CBU_BIT_Z];
      flagN = core_status_register[`CBU_BIT_N];
      flagV = core_status_register[`CBU_BIT_V];
      flagH = core_status_register[`CBU_BIT_H];
      flagT = core_status_register[`CBU_BIT_T];
      // Signed compares look at N xor V, never at N alone
      nv = flagN ^ flagV;
      case (op)
        // Any status bit chosen by the select field
        `CBU_OP_STATUS_BIT_SET: begin
          branchCondition = core_status_register[sel];
        end
        `CBU_OP_STATUS_BIT_CLEAR: begin
          branchCondition = ~core_status_register[sel];
        end
        // Zero flag
        `CBU_OP_EQUAL: begin
          branchCondition = flagZ;
        end
        `CBU_OP_NOT_EQUAL: begin
          branchCondition = ~flagZ;
        end
        // Carry; the unsigned compare names share these conditions
        `CBU_OP_CARRY_SET: begin
          branchCondition = flagC;
        end
        `CBU_OP_LOWER: begin
          branchCondition = flagC;
        end
        `CBU_OP_CARRY_CLEAR: begin
          branchCondition = ~flagC;
        end
        `CBU_OP_SAME_OR_HIGHER: begin
          branchCondition = ~flagC;
        end
        // Negative flag
        `CBU_OP_MINUS: begin
          branchCondition = flagN;
        end
        `CBU_OP_PLUS: begin
          branchCondition = ~flagN;
        end
        // Signed compare
        `CBU_OP_SIGNED_GE: begin
          branchCondition = ~nv;
        end
        `CBU_OP_SIGNED_LT: begin
          branchCondition = nv;
        end
        // Half carry
        `CBU_OP_HALF_CARRY_SET: begin
          branchCondition = flagH;
        end
        `CBU_OP_HALF_CARRY_CLEAR: begin
          branchCondition = ~flagH;
        end
        // Transfer bit
        `CBU_OP_TRANSFER_BIT_SET: begin
          branchCondition = flagT;
        end
        // Unused code never jumps, so a stray op cannot redirect fetch
        default: begin
          branchCondition = 1'b0;
        end
      endcase
    end
  endfunction

  // Widens the signed offset to PC width by copying its sign bit
  function [PC_W-1:0] signExtend;
    input [OFS_W-1:0] ofs;
    begin
      signExtend = {{(PC_W-OFS_W){ofs[OFS_W-1]}}, ofs};
    end
  endfunction

  // Base plus delta plus one; wraps modulo the PC width like the core
  function [PC_W-1:0] pcAdvance;
    input [PC_W-1:0] base;
    input [PC_W-1:0] delta;
    begin
      pcAdvance = base + delta + {{(PC_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // True while the sequencer may take a new request
  function isIdle;
    input st;
    begin
      isIdle = (st == ST_IDLE);
    end
  endfunction

  // ***************************************************
  // Target arithmetic
  // ***************************************************
  reg state_r;
  reg state_nxt;
  wire condMet;
  wire accept;
  wire acceptTaken;
  wire acceptSkip;
  wire discardCycle;
  wire [PC_W-1:0] offsetExt;
  wire [PC_W-1:0] targetPc;
  wire [PC_W-1:0] seqPc;

  // Sign-extend so negative offsets wrap backwards correctly
  assign offsetExt = signExtend(branchOffset);
  // Taken jumps add the offset; a skip moves on by one word
  assign targetPc = pcAdvance(pcCurrent, offsetExt);
  assign seqPc = pcAdvance(pcCurrent, {PC_W{1'b0}});

  // ***************************************************
  // Condition and acceptance
  // ***************************************************
  // Status is only read here; no path exists to write it back
  assign condMet = branchCondition(branchOp, statusBitSel, coreStatusRegister);
  // A request in the discard cycle is dropped with no sign; the core
  // must not present the next instruction until ready returns
  assign accept = instrValid & isIdle(state_r);
  // Outcome of the accepted request, shared by the output registers
  assign acceptTaken = accept & condMet;
  assign acceptSkip = accept & ~condMet;
  assign discardCycle = (state_r == ST_DISCARD);

  // ***************************************************
  // Sequencer
  // ***************************************************
  // Cycle plan of one branch:
  //   skip  - strobe and done at the accept edge, one cycle in all
  //   taken - strobe and discard first, done one edge later
  // Taken branch spends one extra cycle discarding the prefetched word
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // Only a taken branch needs the extra cycle
        if (accept && condMet) begin
          state_nxt = ST_DISCARD;
        end
      end
      ST_DISCARD: begin
        // The discard lasts exactly one cycle, then requests are taken again
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state; reset lands in idle so the first request is taken
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ***************************************************
  // Registered outputs
  // ***************************************************
  // Ready drops only for the cycle that discards the prefetched word
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      instrReady_r <= 1'b1;
    end else begin
      instrReady_r <= isIdle(state_nxt);
    end
  end

  // One-cycle load strobe for every accepted branch, taken or not
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pcLoad_r <= 1'b0;
    end else begin
      pcLoad_r <= accept;
    end
  end

  // Target holds until the next accepted branch replaces it
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pcTarget_r <= {PC_W{1'b0}};
    end else if (acceptTaken) begin
      pcTarget_r <= targetPc;
    end else if (acceptSkip) begin
      // Fall through to the next sequential word in one cycle
      pcTarget_r <= seqPc;
    end
  end

  // The word fetched behind a taken branch is stale and must be dropped
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fetchDiscard_r <= 1'b0;
    end else begin
      fetchDiscard_r <= acceptTaken;
    end
  end

  // Outcome level of the last accepted branch
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      branchTaken_r <= 1'b0;
    end else if (accept) begin
      branchTaken_r <= condMet;
    end
  end

  // Done pulses in the last cycle: at once for a skip, after discard if taken
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      branchDone_r <= 1'b0;
    end else begin
      branchDone_r <= acceptSkip | discardCycle;
    end
  end

  // Cycle count of the last finished branch, kept for the core's timing
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      branchCycles_r <= 2'h0;
    end else if (acceptSkip) begin
      branchCycles_r <= CYC_SKIP;
    end else if (discardCycle) begin
      branchCycles_r <= CYC_JUMP;
    end
  end

endmodule

// ==== src/cbu_defs.vh ====
// Constants for the conditional branch unit
`ifndef CBU_DEFS_VH
`define CBU_DEFS_VH

// ***************************************************
// Widths
// ***************************************************
`define CBU_PC_W 12
`define CBU_OFS_W 7
`define CBU_OP_W 4
`define CBU_CORE_STATUS_REGISTER_W 8
`define CBU_SEL_W 3

// ***************************************************
// Status register bit positions
// ***************************************************
`define CBU_BIT_C 3'h0
`define CBU_BIT_Z 3'h1
`define CBU_BIT_N 3'h2
`define CBU_BIT_V 3'h3
`define CBU_BIT_S 3'h4
`define CBU_BIT_H 3'h5
`define CBU_BIT_T 3'h6
`define CBU_BIT_I 3'h7

// ***************************************************
// Branch operation codes
// ***************************************************
`define CBU_OP_STATUS_BIT_SET 4'h0
`define CBU_OP_STATUS_BIT_CLEAR 4'h1
`define CBU_OP_EQUAL 4'h2
`define CBU_OP_NOT_EQUAL 4'h3
`define CBU_OP_CARRY_SET 4'h4
`define CBU_OP_CARRY_CLEAR 4'h5
`define CBU_OP_SAME_OR_HIGHER 4'h6
`define CBU_OP_LOWER 4'h7
`define CBU_OP_MINUS 4'h8
`define CBU_OP_PLUS 4'h9
`define CBU_OP_SIGNED_GE 4'ha
`define CBU_OP_SIGNED_LT 4'hb
`define CBU_OP_HALF_CARRY_SET 4'hc
`define CBU_OP_HALF_CARRY_CLEAR 4'hd
`define CBU_OP_TRANSFER_BIT_SET 4'he

// ***************************************************
// Cycle counts
// ***************************************************
`define CBU_CYC_NOT_TAKEN 2'h1
`define CBU_CYC_TAKEN 2'h2

`endif

// ==== bench/cbu_branch_props.sv ====
// Assertion checker for the conditional branch unit
`timescale 1ns/1ps
module cbu_branch_props #(
  parameter PC_W = 12,
  parameter OFS_W = 7
) (
  input wire clk_sys,
  input wire rstn,
  input wire instrValid,
  input wire [3:0] branchOp,
  input wire [OFS_W-1:0] branchOffset,
  input wire [PC_W-1:0] pcCurrent,
  input wire [7:0] coreStatusRegister,
  input wire instrReady_r,
  input wire pcLoad_r,
  input wire [PC_W-1:0] pcTarget_r,
  input wire fetchDiscard_r,
  input wire branchTaken_r,
  input wire branchDone_r,
  input wire [1:0] branchCycles_r
);
  // Accept strobe, jump target and signed-compare flag seen at the accept edge
  wire acc = instrValid && instrReady_r;
  wire nv = coreStatusRegister[2] ^ coreStatusRegister[3];
  wire [PC_W-1:0] jmp = pcCurrent + {{(PC_W-OFS_W){branchOffset[OFS_W-1]}}, branchOffset} + 1'b1;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  property p_ld; acc |=> pcLoad_r; endproperty
  a_ld: assert property (p_ld) else $error("no pc load");
  property p_jt; acc ##1 branchTaken_r |-> pcTarget_r == $past(jmp); endproperty
  a_jt: assert property (p_jt) else $error("bad jump target");
  property p_nt; acc ##1 !branchTaken_r |-> pcTarget_r == $past(pcCurrent) + 1'b1; endproperty
  a_nt: assert property (p_nt) else $error("bad next pc");
  property p_ds; pcLoad_r && branchTaken_r |-> fetchDiscard_r && !branchDone_r; endproperty
  a_ds: assert property (p_ds) else $error("no discard");
  property p_tw; fetchDiscard_r |=> branchDone_r && !pcLoad_r && branchCycles_r == 2'h2; endproperty
  a_tw: assert property (p_tw) else $error("taken not two cycles");
  property p_on; pcLoad_r && !branchTaken_r |-> branchDone_r && branchCycles_r == 2'h1; endproperty
  a_on: assert property (p_on) else $error("skip not one cycle");
  property p_eq; acc && branchOp == 4'h2 |=> branchTaken_r == $past(coreStatusRegister[1]); endproperty
  a_eq: assert property (p_eq) else $error("equal outcome");
  property p_ge; acc && branchOp == 4'ha |=> branchTaken_r != $past(nv); endproperty
  a_ge: assert property (p_ge) else $error("signed ge outcome");
  property p_rf; instrValid && !instrReady_r |=> !pcLoad_r; endproperty
  a_rf: assert property (p_rf) else $error("refused request loaded");
  c_tk: cover property (fetchDiscard_r);
  c_nt: cover property (pcLoad_r && !branchTaken_r);
  c_bb: cover property (pcLoad_r [*2]);
endmodule
bind cbu_branch_unit cbu_branch_props #(.PC_W(PC_W), .OFS_W(OFS_W)) cbu_branch_props_i (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .instrValid(instrValid),
  .branchOp(branchOp),
  .branchOffset(branchOffset),
  .pcCurrent(pcCurrent),
  .coreStatusRegister(coreStatusRegister),
  .instrReady_r(instrReady_r),
  .pcLoad_r(pcLoad_r),
  .pcTarget_r(pcTarget_r),
  .fetchDiscard_r(fetchDiscard_r),
  .branchTaken_r(branchTaken_r),
  .branchDone_r(branchDone_r),
  .branchCycles_r(branchCycles_r)
);

// ==== bench/tb_top.sv ====
// Self-checking testbench for the conditional branch unit
`timescale 1ns/1ps
module tb_top;
  localparam [31:0] PATS = 32'haa55ff00;
  localparam [15:0] WANT1 = 16'h5995;
  reg clk_sys = 1'b0;
  reg rstn = 1'b0;
  reg instrValid = 1'b0;
  reg [3:0] branchOp = 4'h0;
  reg [2:0] statusBitSel = 3'h0;
  reg [6:0] branchOffset = 7'h0;
  reg [11:0] pcCurrent = 12'h0;
  reg [7:0] coreStatusRegister = 8'h0;
  wire instrReady_r, pcLoad_r, fetchDiscard_r, branchTaken_r, branchDone_r;
  wire [11:0] pcTarget_r;
  wire [1:0] branchCycles_r;
  integer num_errors = 0, num_checks = 0, cyc = 0, i;
  cbu_branch_unit cbu_branch_unit_i (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .instrValid(instrValid),
    .branchOp(branchOp),
    .statusBitSel(statusBitSel),
    .branchOffset(branchOffset),
    .pcCurrent(pcCurrent),
    .coreStatusRegister(coreStatusRegister),
    .instrReady_r(instrReady_r),
    .pcLoad_r(pcLoad_r),
    .pcTarget_r(pcTarget_r),
    .fetchDiscard_r(fetchDiscard_r),
    .branchTaken_r(branchTaken_r),
    .branchDone_r(branchDone_r),
    .branchCycles_r(branchCycles_r)
  );
  // Core clock
  initial forever #5 clk_sys = ~clk_sys;
  // Ceiling well above the roughly 180 cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  // Compare; a 1-bit result widens with its unknowns intact
  task chk(input [11:0] got, input [11:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Expected outcome: tested bit against wanted level; code f never jumps
  function taken(input [3:0] op, input [2:0] s, input [7:0] r);
    reg b;
    begin
      b = op < 2 ? r[s] : op < 4 ? r[1] : op < 8 ? r[0] : op < 10 ? r[2] :
        op < 12 ? r[2] ^ r[3] : op < 14 ? r[5] : r[6];
      taken = op != 4'hf && b == WANT1[op];
    end
  endfunction
  // One branch with an idle cycle before it
  task br(input [3:0] op, input [2:0] s, input [6:0] k, input [11:0] pc, input [7:0] r);
    reg t;
    begin
      t = taken(op, s, r);
      @(posedge clk_sys);
      branchOp <= op;
      statusBitSel <= s;
      branchOffset <= k;
      pcCurrent <= pc;
      coreStatusRegister <= r;
      instrValid <= 1'b1;
      @(posedge clk_sys);
      instrValid <= 1'b0;
      #1 chk(branchTaken_r, t);
      chk(pcTarget_r, pc + (t ? {{5{k[6]}}, k} : 12'h0) + 12'h1);
      chk(fetchDiscard_r, t);
      if (t) #10;
      chk(branchDone_r, 1'b1);
      chk(branchCycles_r, t ? 12'h2 : 12'h1);
    end
  endtask
  // Every code against four flag patterns, both offset signs, carry out of the pc low byte
  task test_ops;
    begin
      for (i = 0; i < 64; i = i + 1)
        br(i[3:0], i[5:3] ^ i[2:0], {i[2:0], 4'h9}, {i[3:0], 8'hfc}, PATS[i[5:4]*8 +: 8]);
      $display("test_ops done");
    end
  endtask
  // Two skips back to back, then a taken jump with a request refused behind it
  task test_b2b;
    begin
      @(posedge clk_sys);
      branchOp <= 4'h2;
      branchOffset <= 7'h40;
      coreStatusRegister <= 8'h00;
      pcCurrent <= 12'h100;
      instrValid <= 1'b1;
      @(posedge clk_sys);
      pcCurrent <= 12'h200;
      #1 chk(pcTarget_r, 12'h101);
      @(posedge clk_sys);
      coreStatusRegister <= 8'h02;
      #1 chk(pcTarget_r, 12'h201);
      @(posedge clk_sys);
      #1 chk(pcTarget_r, 12'h1c1);
      chk(instrReady_r, 1'b0);
      @(posedge clk_sys);
      instrValid <= 1'b0;
      #1 chk(branchCycles_r, 12'h2);
      chk(pcLoad_r, 1'b0);
      chk(instrReady_r, 1'b1);
      @(posedge clk_sys);
      #1 chk(pcLoad_r, 1'b0);
      $display("test_b2b done");
    end
  endtask
  // Verdict
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Main sequence: reset for 12 cycles, then the tests
  initial begin
    repeat (11) @(posedge clk_sys);
    #1 chk(pcLoad_r, 1'b0);
    chk(instrReady_r, 1'b1);
    @(posedge clk_sys);
    rstn <= 1'b1;
    test_ops;
    test_b2b;
    wrap_up;
  end
endmodule
